// ===== core/smux_pkg.sv
// package for the audio sample-rate multiplexer: sizes, rates, timing counts and carriers
// assumes a single 50 MHz system clock shared by the audio and link-side logic
`default_nettype none
package smux_pkg;
    // --------------------------------------------------------------
    // frame geometry
    // --------------------------------------------------------------
    localparam int SLOT_COUNT      = 64;   // slots in a single-rate frame
    localparam int NATIVE96_SLOTS  = 32;   // channels in a native double-rate frame
    localparam int SAMPLE_BITS     = 24;   // internal sample width in every mode
    localparam int SLOT_BITS       = 6;
    localparam int PHASE_BITS      = 2;

    // --------------------------------------------------------------
    // base rates in Hz and the internal-rate output width
    // --------------------------------------------------------------
    localparam int RATE_BITS       = 18;
    localparam logic [RATE_BITS-1:0] BASE_32K_HZ  = 18'h07D00; // 32000
    localparam logic [RATE_BITS-1:0] BASE_44K1_HZ = 18'h0AC44; // 44100
    localparam logic [RATE_BITS-1:0] BASE_48K_HZ  = 18'h0BB80; // 48000

    // --------------------------------------------------------------
    // clock recovery timing
    // --------------------------------------------------------------
    localparam int CLK_HZ          = 50_000_000;
    localparam int LOCK_MIN_HZ     = 25_000;
    localparam int LOCK_MAX_HZ     = 200_000;
    localparam int PERIOD_BITS     = 12;
    // longest period rounds down, shortest rounds up
    localparam logic [PERIOD_BITS-1:0] PERIOD_MAX_CYC =
        PERIOD_BITS'(CLK_HZ / LOCK_MIN_HZ);
    localparam logic [PERIOD_BITS-1:0] PERIOD_MIN_CYC =
        PERIOD_BITS'((CLK_HZ + LOCK_MAX_HZ - 1) / LOCK_MAX_HZ);
    localparam logic [PERIOD_BITS-1:0] PERIOD_TOL_CYC = 12'h008; // allowed drift per period
    localparam logic [2:0]             LOCK_NEED      = 3'h4;    // good periods before lock

    // --------------------------------------------------------------
    // modes and carriers
    // --------------------------------------------------------------
    typedef enum logic [1:0] {RATE_SINGLE, RATE_DOUBLE, RATE_QUAD} rate_mode_t;
    typedef enum logic       {FRAME_48K, FRAME_96K}               frame_fmt_t;
    typedef enum logic [1:0] {BASE_32K, BASE_44K1, BASE_48K}      base_rate_t;

    typedef struct packed {
        logic [SLOT_BITS-1:0]   ch;
        logic [PHASE_BITS-1:0]  phase;
        logic [SAMPLE_BITS-1:0] data;
    } aud_sample_t;

    typedef struct packed {
        logic [SLOT_BITS-1:0]   num;
        logic [SAMPLE_BITS-1:0] data;
    } slot_word_t;
endpackage
`default_nettype wire

// ===== core/smux_core.sv
// sample-rate multiplexer between the internal audio stream and link frame slots
// assumes the link framer presents slot requests and received slots on i_clk,
// and that the recovered word clock arrives asynchronously on i_word_clk
//
// Notes on behaviour
// - double rate runs the internal sample clock at twice the base rate
// - samples stay 24 bits wide in every rate mode
// - 96 kHz goes both ways as two-slot interleave or native double-rate frame
// - double rate in single-rate frame uses two slots per channel, 32 channels
// - quad rate in single-rate frame uses four slots per channel, 16 channels
// - 192 kHz only by four-slot interleave, never a native quad frame
// - interleaved modes keep the link at the single-speed frame rate
// - successive samples of a channel rotate over the two or four slots of its group
// - interleave and de-interleave only move samples, never change them
// - single-rate frame carries at most 64 channels up to 48 kHz
// - native double-rate frame carries at most 32 channels
// - native double-rate receive picks its rate itself; interleave needs manual set
// - clock recovery locks on 25 kHz to 200 kHz and tracks varispeed
// - 32, 44.1 and 48 kHz are the base rates, multiplied by two or four
`default_nettype none
module smux_core
    import smux_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    // configuration levels
    input  wire rate_mode_t             i_rate_mode,
    input  wire frame_fmt_t             i_frame_fmt,
    input  wire base_rate_t             i_base_rate,
    // recovered word clock pin
    input  wire logic                   i_word_clk,
    // audio side, transmit direction
    input  wire logic                   i_tx_valid,
    input  wire aud_sample_t            i_tx_sample,
    output logic                        o_tx_ready,
    // link side, transmit slot requests
    input  wire logic                   i_tx_slot_req,
    input  wire logic [SLOT_BITS-1:0]   i_tx_slot_num,
    output logic                        o_tx_slot_valid,
    output slot_word_t                  o_tx_slot,
    output logic                        o_tx_underrun,
    // link side, received slots
    input  wire logic                   i_rx_slot_valid,
    input  wire slot_word_t             i_rx_slot,
    input  wire logic                   i_rx_native96,
    // audio side, receive direction
    output logic                        o_rx_valid,
    output aud_sample_t                 o_rx_sample,
    // status
    output logic [RATE_BITS-1:0]        o_internal_rate_hz,
    output logic [SLOT_BITS:0]          o_channel_count,
    output logic                        o_rx_double_rate,
    output logic                        o_locked,
    output logic [PERIOD_BITS-1:0]      o_word_period
);

    // --------------------------------------------------------------
    // mode decode
    // --------------------------------------------------------------
    frame_fmt_t             tx_fmt;
    frame_fmt_t             rx_fmt;
    logic [PHASE_BITS-1:0]  tx_shift;
    logic [PHASE_BITS-1:0]  rx_shift;
    logic [PHASE_BITS-1:0]  rate_shift;
    logic [RATE_BITS-1:0]   base_hz;

    // quad rate has no native frame, so it always uses the single-rate frame
    assign tx_fmt = (i_rate_mode == RATE_QUAD) ? FRAME_48K : i_frame_fmt;
    // a native double-rate frame announces itself; interleave follows the setting
    assign rx_fmt = i_rx_native96 ? FRAME_96K : tx_fmt;

    // the link speed never changes; only the slot mapping follows the mode
    // slots per channel as a shift: one, two or four slots per group
    always_comb begin
        rate_shift = 2'h0;
        case (i_rate_mode)
            RATE_DOUBLE: rate_shift = 2'h1;
            RATE_QUAD:   rate_shift = 2'h2;
            default:     rate_shift = 2'h0;
        endcase
        tx_shift = (tx_fmt == FRAME_96K) ? 2'h0 : rate_shift;
        rx_shift = (rx_fmt == FRAME_96K) ? 2'h0 : rate_shift;
    end

    // base rate table
    // doubled and quadrupled rates come from a shift, not a second table
    always_comb begin
        case (i_base_rate)
            BASE_32K:  base_hz = BASE_32K_HZ;
            BASE_44K1: base_hz = BASE_44K1_HZ;
            default:   base_hz = BASE_48K_HZ;
        endcase
    end

    // --------------------------------------------------------------
    // rate and channel-count status
    // --------------------------------------------------------------
    // status follows the configuration inputs one edge later
    // native frame counts as double rate even with a single-rate setting
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_internal_rate_hz <= BASE_48K_HZ;
            o_channel_count    <= 7'(SLOT_COUNT);
            o_rx_double_rate   <= 1'b0;
        end else begin
            if (tx_fmt == FRAME_96K && rate_shift == 2'h0)
                o_internal_rate_hz <= base_hz << 1;
            else
                o_internal_rate_hz <= base_hz << rate_shift;
            if (tx_fmt == FRAME_96K)
                o_channel_count <= 7'(NATIVE96_SLOTS);
            else
                o_channel_count <= 7'(SLOT_COUNT) >> tx_shift;
            o_rx_double_rate <= (rx_fmt == FRAME_96K) || (rate_shift == 2'h1);
        end
    end

    // --------------------------------------------------------------
    // transmit slot buffer
    // --------------------------------------------------------------
    // one sample per slot keeps latency below a frame but leaves no slack
    logic [SAMPLE_BITS-1:0] tx_buf     [SLOT_COUNT];
    logic [SLOT_COUNT-1:0]  tx_full_q;
    logic [PHASE_BITS-1:0]  tx_phase_q [SLOT_COUNT];
    logic [4:0]             cfg_q;
    logic                   cfg_change;
    logic [SLOT_BITS-1:0]   wr_slot;
    logic                   wr_in_range;
    logic                   wr_fire;
    logic                   rd_active;
    logic [SLOT_BITS:0]     slot_limit;

    assign cfg_change  = cfg_q != {i_rate_mode, tx_fmt, i_base_rate};
    assign slot_limit  = (tx_fmt == FRAME_96K) ? 7'(NATIVE96_SLOTS) : 7'(SLOT_COUNT);
    assign wr_in_range = {1'b0, i_tx_sample.ch} < (slot_limit >> tx_shift);
    // group base is channel times group size; phase picks the slot inside it
    assign wr_slot     = SLOT_BITS'(i_tx_sample.ch << tx_shift)
                       | SLOT_BITS'(tx_phase_q[i_tx_sample.ch]);
    // out-of-range channels are taken and dropped so the source never hangs
    assign o_tx_ready  = !cfg_change && (!wr_in_range || !tx_full_q[wr_slot]);
    assign wr_fire     = i_tx_valid && o_tx_ready && wr_in_range;
    assign rd_active   = {1'b0, i_tx_slot_num} < slot_limit;

    // remember the configuration; a change flushes the buffer below
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            cfg_q <= 5'h00;
        else
            cfg_q <= {i_rate_mode, tx_fmt, i_base_rate};
    end

    // sample storage, written unchanged and read unchanged
    always_ff @(posedge i_clk) begin
        if (wr_fire)
            tx_buf[wr_slot] <= i_tx_sample.data;
    end

    // per-entry fill flags and per-channel phase counters
    generate
        for (genvar s = 0; s < SLOT_COUNT; s++) begin : g_slot
            logic set_here;
            logic clr_here;
            logic adv_here;
            assign set_here = wr_fire && wr_slot == SLOT_BITS'(s);
            assign clr_here = i_tx_slot_req && i_tx_slot_num == SLOT_BITS'(s);
            assign adv_here = wr_fire && i_tx_sample.ch == SLOT_BITS'(s);
            // a write landing in the cycle of a read keeps the slot filled
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn)
                    tx_full_q[s] <= 1'b0;
                else if (cfg_change)
                    tx_full_q[s] <= 1'b0;
                else if (set_here)
                    tx_full_q[s] <= 1'b1;
                else if (clr_here)
                    tx_full_q[s] <= 1'b0;
            end
            // earliest sample goes to the lowest slot, then upward, then wrap
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn)
                    tx_phase_q[s] <= 2'h0;
                else if (cfg_change)
                    tx_phase_q[s] <= 2'h0;
                else if (adv_here)
                    tx_phase_q[s] <= (tx_phase_q[s] + 2'h1)
                                   & PHASE_BITS'((1 << tx_shift) - 1);
            end
        end
    endgenerate

    // link read: one slot per request, unfilled or unused slots send silence
    // the slot number is echoed so the framer can check it against its count
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_tx_slot_valid <= 1'b0;
            o_tx_slot       <= '0;
            o_tx_underrun   <= 1'b0;
        end else begin
            o_tx_slot_valid <= i_tx_slot_req;
            o_tx_underrun   <= i_tx_slot_req && rd_active && !tx_full_q[i_tx_slot_num];
            if (i_tx_slot_req) begin
                o_tx_slot.num <= i_tx_slot_num;
                if (rd_active && tx_full_q[i_tx_slot_num])
                    o_tx_slot.data <= tx_buf[i_tx_slot_num];
                else
                    o_tx_slot.data <= '0;
            end
        end
    end

    // --------------------------------------------------------------
    // receive de-interleave
    // --------------------------------------------------------------
    logic [SLOT_BITS:0] rx_limit;
    assign rx_limit = (rx_fmt == FRAME_96K) ? 7'(NATIVE96_SLOTS) : 7'(SLOT_COUNT);

    // slot number splits into channel and phase; data passes untouched
    // no buffer here: the audio side must take every valid pulse as it comes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rx_valid  <= 1'b0;
            o_rx_sample <= '0;
        end else begin
            o_rx_valid <= i_rx_slot_valid && ({1'b0, i_rx_slot.num} < rx_limit);
            if (i_rx_slot_valid) begin
                o_rx_sample.ch    <= i_rx_slot.num >> rx_shift;
                o_rx_sample.phase <= PHASE_BITS'(i_rx_slot.num)
                                   & PHASE_BITS'((1 << rx_shift) - 1);
                o_rx_sample.data  <= i_rx_slot.data;
            end
        end
    end

    // --------------------------------------------------------------
    // word clock recovery
    // --------------------------------------------------------------
    logic [2:0]             wc_sync_q;
    logic                   wc_clean_q;
    logic                   wc_rise;
    logic [PERIOD_BITS-1:0] per_cnt_q;
    logic [PERIOD_BITS-1:0] per_diff;
    logic                   per_good;
    logic [2:0]             good_cnt_q;

    // three-stage synchroniser; the clean level moves only when stages two and three agree
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wc_sync_q  <= 3'h0;
            wc_clean_q <= 1'b0;
        end else begin
            wc_sync_q <= {wc_sync_q[1:0], i_word_clk};
            if (wc_sync_q[1] == wc_sync_q[2])
                wc_clean_q <= wc_sync_q[2];
        end
    end

    assign wc_rise  = wc_sync_q[2] && wc_sync_q[1] && !wc_clean_q;
    assign per_diff = (per_cnt_q > o_word_period) ? per_cnt_q - o_word_period
                                                  : o_word_period - per_cnt_q;
    // inside the lock range and close to the last period: tracks slow varispeed
    assign per_good = per_cnt_q >= PERIOD_MIN_CYC && per_cnt_q <= PERIOD_MAX_CYC
                   && per_diff <= PERIOD_TOL_CYC;

    // period counter saturates so a stopped clock cannot wrap into range
    // a missing edge is caught once the count passes PERIOD_MAX_CYC, not by a separate watchdog
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            per_cnt_q <= '0;
        else if (wc_rise)
            per_cnt_q <= 12'h001;
        else if (per_cnt_q != '1)
            per_cnt_q <= per_cnt_q + 12'h001;
    end

    // lock after a few matching periods; lose it on a bad or missing edge
    // one bad period drops lock at once, so a glitch never passes as varispeed
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_word_period <= '0;
            good_cnt_q    <= 3'h0;
            o_locked      <= 1'b0;
        end else if (wc_rise) begin
            o_word_period <= per_cnt_q;
            if (per_good) begin
                if (good_cnt_q != LOCK_NEED)
                    good_cnt_q <= good_cnt_q + 3'h1;
                o_locked <= (good_cnt_q >= LOCK_NEED - 3'h1);
            end else begin
                good_cnt_q <= 3'h0;
                o_locked   <= 1'b0;
            end
        end else if (per_cnt_q > PERIOD_MAX_CYC) begin
            good_cnt_q <= 3'h0;
            o_locked   <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== tb/smux_assertions.sv
// checker for smux_core: link slot answers, receive limit and status outputs
// assumes a bind onto smux_core, one clock domain, reset active low
`default_nettype none
module smux_assertions
    import smux_pkg::*;
(
    // clock, reset and configuration
    input wire logic                   i_clk,
    input wire logic                   i_resetn,
    input wire rate_mode_t             i_rate_mode,
    input wire frame_fmt_t             i_frame_fmt,
    input wire base_rate_t             i_base_rate,
    input wire logic                   i_rx_native96,
    // link side
    input wire logic                   i_tx_slot_req,
    input wire logic [SLOT_BITS-1:0]   i_tx_slot_num,
    input wire logic                   o_tx_slot_valid,
    input wire slot_word_t             o_tx_slot,
    input wire logic                   o_tx_underrun,
    input wire logic                   i_rx_slot_valid,
    input wire slot_word_t             i_rx_slot,
    // audio side and status
    input wire logic                   o_rx_valid,
    input wire aud_sample_t            o_rx_sample,
    input wire logic [RATE_BITS-1:0]   o_internal_rate_hz,
    input wire logic [SLOT_BITS:0]     o_channel_count,
    input wire logic                   o_rx_double_rate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // ----------------------------------------
    // transmit slots
    // ----------------------------------------
    sequence slot_req_s;
        i_tx_slot_req;
    endsequence
    // the answer names the slot that was asked for, one cycle later
    sequence slot_ans_s;
        o_tx_slot_valid && o_tx_slot.num == $past(i_tx_slot_num);
    endsequence
    slot_answer_a: assert property (slot_req_s |=> slot_ans_s)
        else $error("slot request not answered next cycle");
    stray_valid_a: assert property (o_tx_slot_valid |-> $past(i_tx_slot_req))
        else $error("slot answer without request");
    underrun_zero_a: assert property (
        o_tx_underrun |-> o_tx_slot_valid && o_tx_slot.data == '0)
        else $error("underrun without zero data");
    // ----------------------------------------
    // receive slots
    // ----------------------------------------
    rx_data_kept_a: assert property (
        i_rx_slot_valid && i_rx_slot.num < 6'h20
        |=> o_rx_valid && o_rx_sample.data == $past(i_rx_slot.data))
        else $error("received sample lost or altered");
    native_limit_a: assert property (
        i_rx_slot_valid && i_rx_native96 && i_rx_slot.num >= 6'h20 |=> !o_rx_valid)
        else $error("native frame slot above 31 delivered");
    native_detect_a: assert property (i_rx_native96 |=> o_rx_double_rate)
        else $error("native frame rate not detected");
    // ----------------------------------------
    // status
    // ----------------------------------------
    double_count_a: assert property (
        i_rate_mode == RATE_DOUBLE |=> o_channel_count == 7'h20)
        else $error("double rate channel count wrong");
    quad_count_a: assert property (
        i_rate_mode == RATE_QUAD && !i_rx_native96 |=> o_channel_count == 7'h10)
        else $error("quad rate channel count wrong");
    single_count_a: assert property (
        i_rate_mode == RATE_SINGLE && i_frame_fmt == FRAME_48K && !i_rx_native96
        |=> o_channel_count == 7'h40)
        else $error("single rate channel count wrong");
    double_hz_a: assert property (
        i_rate_mode == RATE_DOUBLE && i_base_rate == BASE_48K
        |=> o_internal_rate_hz == 18'h17700)
        else $error("double rate clock wrong");
    quad_hz_a: assert property (
        i_rate_mode == RATE_QUAD && i_base_rate == BASE_44K1 && !i_rx_native96
        |=> o_internal_rate_hz == 18'h2B110)
        else $error("quad rate clock wrong");
endmodule
`default_nettype wire

// ===== tb/link_partner.sv
// model of the far-side link equipment: word clock, slot reader and slot sender
// assumes its tasks are entered 2 ns after a rising edge of i_clk
`default_nettype none
module link_partner
    import smux_pkg::*;
(
    // clock
    input  wire logic              i_clk,
    // link lines towards the multiplexer
    output var logic               o_word_clk,
    output var logic               o_slot_req,
    output var logic [SLOT_BITS-1:0] o_slot_num, // six bits: 64 slots at most
    output var logic               o_rx_valid,
    output var slot_word_t         o_rx_slot,
    output var logic               o_native96
);
    timeunit 1ns;
    timeprecision 1ns;
    int half_ns = 10417; // about 48 kHz, a single-speed rate even when interleaving
    // word clock runs free; the half period may be changed to leave the lock range
    initial begin
        o_word_clk = 1'b0;
        forever #(half_ns) o_word_clk = ~o_word_clk;
    end
    initial begin
        o_slot_req = 1'b0;
        o_slot_num = '0;
        o_rx_valid = 1'b0;
        o_rx_slot  = '0;
        o_native96 = 1'b0;
    end
    // one request; a released number flips so a stale value never passes for a live one
    task automatic read_slot(input logic [SLOT_BITS-1:0] num);
        o_slot_req = 1'b1;
        o_slot_num = num;
        @(posedge i_clk);
        #2;
        o_slot_req = 1'b0;
        o_slot_num = ~num;
    endtask
    // one received slot; the native flag stays as a level until the next slot
    task automatic send_slot(input logic [SLOT_BITS-1:0] num,
                             input logic [SAMPLE_BITS-1:0] d, input logic nat);
        o_native96 = nat;
        o_rx_valid = 1'b1;
        o_rx_slot  = {num, d}; // sample sent unaltered
        @(posedge i_clk);
        #2;
        o_rx_valid = 1'b0;
        o_rx_slot  = ~o_rx_slot;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for smux_core: status, interleaved transmit, receive and lock
// assumes smux_pkg, smux_core, link_partner and smux_assertions compiled before it
`default_nettype none
module tb
    import smux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [RATE_BITS-1:0] HZ [3] = '{BASE_32K_HZ, BASE_44K1_HZ, BASE_48K_HZ};
    logic                   i_clk = 1'b0;
    logic                   i_resetn = 1'b0;
    rate_mode_t             rate_mode = RATE_SINGLE;
    frame_fmt_t             frame_fmt = FRAME_48K;
    base_rate_t             base_rate = BASE_48K;
    logic                   tx_valid = 1'b0;
    aud_sample_t            tx_sample = '0;
    logic                   word_clk, slot_req, rx_valid_in, native96;
    logic [SLOT_BITS-1:0]   slot_num;
    slot_word_t             rx_slot_in, tx_slot;
    logic                   tx_ready, tx_slot_valid, tx_underrun, rx_valid, rx_double, locked;
    aud_sample_t            rx_sample;
    logic [RATE_BITS-1:0]   rate_hz;
    logic [SLOT_BITS:0]     ch_count;
    logic [PERIOD_BITS-1:0] word_period;
    int                     fails = 0;
    int                     n_checks = 0;
    smux_core i_smux_core(.i_clk(i_clk), .i_resetn(i_resetn), .i_rate_mode(rate_mode),
        .i_frame_fmt(frame_fmt), .i_base_rate(base_rate), .i_word_clk(word_clk),
        .i_tx_valid(tx_valid), .i_tx_sample(tx_sample), .o_tx_ready(tx_ready),
        .i_tx_slot_req(slot_req), .i_tx_slot_num(slot_num), .o_tx_slot_valid(tx_slot_valid),
        .o_tx_slot(tx_slot), .o_tx_underrun(tx_underrun), .i_rx_slot_valid(rx_valid_in),
        .i_rx_slot(rx_slot_in), .i_rx_native96(native96), .o_rx_valid(rx_valid),
        .o_rx_sample(rx_sample), .o_internal_rate_hz(rate_hz), .o_channel_count(ch_count),
        .o_rx_double_rate(rx_double), .o_locked(locked), .o_word_period(word_period));
    link_partner u_link(.i_clk(i_clk), .o_word_clk(word_clk), .o_slot_req(slot_req),
        .o_slot_num(slot_num), .o_rx_valid(rx_valid_in), .o_rx_slot(rx_slot_in),
        .o_native96(native96));
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    // a config change flushes slots, so two edges pass before traffic
    task automatic set_cfg(input rate_mode_t m, input frame_fmt_t f, input base_rate_t b);
        rate_mode = m;
        frame_fmt = f;
        base_rate = b;
        step(2);
    endtask
    // offer one sample; valid is left high so back-to-back offers need no gap
    task automatic put(input logic [5:0] ch, input logic [23:0] d);
        int n;
        tx_valid = 1'b1;
        tx_sample = {ch, 2'h0, d};
        #1;
        for (n = 0; n < 50 && tx_ready !== 1'b1; n++) begin
            step();
            #1;
        end
        if (n == 50) begin
            fails++;
            stop_test();
        end
        step();
    endtask
    // fill one channel's group, see the next offer refused, then read the group back
    task automatic tx_group(input int g, input logic [5:0] ch);
        for (int k = 0; k < g; k++) put(ch, 24'hC00000 + 24'(k));
        tx_sample = {ch, 2'h0, 24'hFFFFFF};
        #1;
        chk(tx_ready, 1'b0);
        step();
        tx_valid = 1'b0;
        for (int k = 0; k < g; k++) begin
            u_link.read_slot(6'(int'(ch) * g + k));
            chk(tx_slot_valid, 1'b1);
            chk(tx_slot, {6'(int'(ch) * g + k), 24'hC00000 + 24'(k)});
            chk(tx_underrun, 1'b0);
            step();
        end
        u_link.read_slot(6'(int'(ch) * g));
        chk({tx_underrun, tx_slot.data}, 25'h1000000);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_status;
        for (int m = 0; m < 3; m++) begin
            for (int b = 0; b < 3; b++) begin
                set_cfg(rate_mode_t'(m), FRAME_48K, base_rate_t'(b));
                chk(rate_hz, HZ[b] << m);
                chk(ch_count, 64 >> m);
            end
        end
        set_cfg(RATE_SINGLE, FRAME_96K, BASE_44K1);
        chk({ch_count, rate_hz}, {7'h20, 18'h15888});
        set_cfg(RATE_QUAD, FRAME_96K, BASE_48K);
        chk({ch_count, rate_hz}, {7'h10, 18'h2EE00});
    endtask
    task automatic t_tx;
        set_cfg(RATE_DOUBLE, FRAME_48K, BASE_44K1);
        tx_group(2, 6'h05);
        set_cfg(RATE_QUAD, FRAME_96K, BASE_48K);
        tx_group(4, 6'h0F);
    endtask
    task automatic t_rx;
        set_cfg(RATE_QUAD, FRAME_48K, BASE_48K);
        u_link.send_slot(6'h0D, 24'h123456, 1'b0);
        chk({rx_valid, rx_sample}, {1'b1, 6'h03, 2'h1, 24'h123456});
        set_cfg(RATE_DOUBLE, FRAME_48K, BASE_48K);
        u_link.send_slot(6'h3F, 24'hABCDEF, 1'b0);
        chk({rx_valid, rx_sample}, {1'b1, 6'h1F, 2'h1, 24'hABCDEF});
        set_cfg(RATE_SINGLE, FRAME_48K, BASE_48K);
        u_link.send_slot(6'h28, 24'h555555, 1'b1);
        chk({rx_valid, rx_double, rate_hz}, {1'b0, 1'b1, BASE_48K_HZ});
        step();
        u_link.send_slot(6'h09, 24'hAAAAAA, 1'b0);
        chk({rx_valid, rx_sample}, {1'b1, 6'h09, 2'h0, 24'hAAAAAA});
    endtask
    task automatic t_lock;
        int n;
        for (n = 0; n < 10000 && locked !== 1'b1; n++) step();
        chk(locked, 1'b1);
        chk(word_period >= 12'h410 && word_period <= 12'h413, 1'b1);
        u_link.half_ns = 30000;
        for (n = 0; n < 8000 && locked !== 1'b0; n++) step();
        chk(locked, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        #2;
        i_resetn = 1'b1;
        step(2);
        t_status();
        t_tx();
        t_rx();
        t_lock();
        stop_test();
    end
endmodule
bind smux_core smux_assertions u_chk(.i_clk(i_clk), .i_resetn(i_resetn),
    .i_rate_mode(i_rate_mode), .i_frame_fmt(i_frame_fmt), .i_base_rate(i_base_rate),
    .i_rx_native96(i_rx_native96), .i_tx_slot_req(i_tx_slot_req),
    .i_tx_slot_num(i_tx_slot_num), .o_tx_slot_valid(o_tx_slot_valid),
    .o_tx_slot(o_tx_slot), .o_tx_underrun(o_tx_underrun), .i_rx_slot_valid(i_rx_slot_valid),
    .i_rx_slot(i_rx_slot), .o_rx_valid(o_rx_valid), .o_rx_sample(o_rx_sample),
    .o_internal_rate_hz(o_internal_rate_hz), .o_channel_count(o_channel_count),
    .o_rx_double_rate(o_rx_double_rate));
`default_nettype wire
